// ===== design/ppcr_pkg.sv
// package for the port pin configuration registers: offsets, resets, types
// assumes a byte-wide special function register access, one clock domain
package ppcr_pkg;

	// ****************************************
	// register offsets in function register space
	// ****************************************
	localparam logic [7:0] PORT1_DATA_LATCH_ADDR        = 8'h90;
	localparam logic [7:0] PORT1_OUTPUT_DRIVE_MODE_ADDR = 8'hA5;
	localparam logic [7:0] PORT0_CROSSBAR_SKIP_ADDR     = 8'hD4;
	localparam logic [7:0] PORT1_CROSSBAR_SKIP_ADDR     = 8'hD5;
	localparam logic [7:0] PORT1_ANALOG_SELECT_ADDR     = 8'hF2;

	// bit address space: bits 0x90..0x97 map to the data latch bits 0..7
	localparam logic [4:0] PORT1_BIT_GROUP              = 5'h12;
	localparam int         BIT_INDEX_MSB                = 2;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] PORT1_DATA_LATCH_RST         = 8'hFF;
	localparam logic [7:0] PORT1_OUTPUT_DRIVE_MODE_RST  = 8'h00;
	localparam logic [7:0] PORT0_CROSSBAR_SKIP_RST      = 8'h00;
	localparam logic [7:0] PORT1_CROSSBAR_SKIP_RST      = 8'h00;
	localparam logic [7:0] PORT1_ANALOG_SELECT_RST      = 8'hFF;
	localparam logic [7:0] UNMAPPED_READ_VALUE          = 8'h00;

	localparam int         PORT_WIDTH                   = 8;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic       wr;      // write strobe
		logic       rd;      // read strobe
		logic       bit_op;  // addr is a bit address, data in wdata[0]
		logic       rmw;     // read-modify-write: read the latch
		logic [7:0] addr;
		logic [7:0] wdata;
	} ppcr_sfr_req_t;

	typedef struct packed {
		logic [7:0] out;       // level driven when enabled
		logic [7:0] oe;        // driver enable
		logic [7:0] pullup_en; // weak pull-up enable
		logic [7:0] dig_in_en; // digital receiver enable
	} ppcr_pin_drive_t;

endpackage

// ===== design/ppcr_port_regs.sv
// port 0 skip and port 1 data/mode/skip registers with the port 1 pad control
// assumes the core issues one-cycle strobes; pins are asynchronous to clk
// assumes the crossbar decoder and the pad cells sit outside this block
module ppcr_port_regs (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst,
	// function register access
	input  wire ppcr_pkg::ppcr_sfr_req_t sfr_req,
	output logic [7:0]                  sfr_rdata,
	output logic                        sfr_rvalid,
	// port 1 pads
	input  wire logic [7:0]             port1_pin_in,
	output ppcr_pkg::ppcr_pin_drive_t   port1_pad,
	// to the crossbar decoder
	output logic [7:0]                  port0_skip_out,
	output logic [7:0]                  port1_skip_out
);

	// ****************************************
	// register state
	// ****************************************
	logic [7:0] port1_data_latch_reg,        port1_data_latch_next;
	logic [7:0] port1_output_drive_mode_reg, port1_output_drive_mode_next;
	logic [7:0] port0_crossbar_skip_reg,     port0_crossbar_skip_next;
	logic [7:0] port1_crossbar_skip_reg,     port1_crossbar_skip_next;
	logic [7:0] port1_analog_select_reg,     port1_analog_select_next;
	logic [7:0] rdata_reg,                   rdata_next;
	logic       rvalid_reg,                  rvalid_next;
	logic [7:0] pin_meta_reg;
	logic [7:0] pin_sync_reg;
	logic [7:0] pin_level;
	logic       bit_hit;
	logic [2:0] bit_idx;

	// the bit group shares its upper five address bits with the data byte
	assign bit_hit = sfr_req.bit_op &&
		(sfr_req.addr[7:3] == ppcr_pkg::PORT1_BIT_GROUP);
	assign bit_idx = sfr_req.addr[ppcr_pkg::BIT_INDEX_MSB:0];

	// analog pins read low: their receiver is switched off
	assign pin_level = pin_sync_reg & port1_analog_select_reg;

	// ****************************************
	// register writes and reads
	// ****************************************
	// a write and a read in the same cycle: the read answers with the
	// value from before the write
	always_comb begin
		port1_data_latch_next        = port1_data_latch_reg;
		port1_output_drive_mode_next = port1_output_drive_mode_reg;
		port0_crossbar_skip_next     = port0_crossbar_skip_reg;
		port1_crossbar_skip_next     = port1_crossbar_skip_reg;
		port1_analog_select_next     = port1_analog_select_reg;
		rdata_next                   = rdata_reg;
		// one-cycle answer; rdata holds until the next read replaces it
		rvalid_next                  = sfr_req.rd;
		if (sfr_req.wr) begin
			if (sfr_req.bit_op) begin
				// a bit write only touches its own latch bit, so the
				// other latch bits keep their stored value
				if (bit_hit) begin
					port1_data_latch_next[bit_idx] = sfr_req.wdata[0];
				end
			end else begin
				unique case (sfr_req.addr)
					ppcr_pkg::PORT1_DATA_LATCH_ADDR: begin
						port1_data_latch_next = sfr_req.wdata;
					end
					ppcr_pkg::PORT1_OUTPUT_DRIVE_MODE_ADDR: begin
						port1_output_drive_mode_next = sfr_req.wdata;
					end
					ppcr_pkg::PORT0_CROSSBAR_SKIP_ADDR: begin
						port0_crossbar_skip_next = sfr_req.wdata;
					end
					ppcr_pkg::PORT1_CROSSBAR_SKIP_ADDR: begin
						port1_crossbar_skip_next = sfr_req.wdata;
					end
					ppcr_pkg::PORT1_ANALOG_SELECT_ADDR: begin
						port1_analog_select_next = sfr_req.wdata;
					end
					default: begin
					end
				endcase
			end
		end
		if (sfr_req.rd) begin
			// unmapped bytes and foreign bit addresses read as zero;
			// bit reads answer in bit 0 only, the upper bits stay zero
			rdata_next = ppcr_pkg::UNMAPPED_READ_VALUE;
			if (sfr_req.bit_op) begin
				if (bit_hit) begin
					rdata_next[0] = sfr_req.rmw ?
						port1_data_latch_reg[bit_idx] :
						pin_level[bit_idx];
				end
			end else begin
				unique case (sfr_req.addr)
					ppcr_pkg::PORT1_DATA_LATCH_ADDR: begin
						rdata_next = sfr_req.rmw ?
							port1_data_latch_reg : pin_level;
					end
					ppcr_pkg::PORT1_OUTPUT_DRIVE_MODE_ADDR: begin
						rdata_next = port1_output_drive_mode_reg;
					end
					ppcr_pkg::PORT0_CROSSBAR_SKIP_ADDR: begin
						rdata_next = port0_crossbar_skip_reg;
					end
					ppcr_pkg::PORT1_CROSSBAR_SKIP_ADDR: begin
						rdata_next = port1_crossbar_skip_reg;
					end
					ppcr_pkg::PORT1_ANALOG_SELECT_ADDR: begin
						rdata_next = port1_analog_select_reg;
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			port1_data_latch_reg        <= ppcr_pkg::PORT1_DATA_LATCH_RST;
			port1_output_drive_mode_reg <= ppcr_pkg::PORT1_OUTPUT_DRIVE_MODE_RST;
			port0_crossbar_skip_reg     <= ppcr_pkg::PORT0_CROSSBAR_SKIP_RST;
			port1_crossbar_skip_reg     <= ppcr_pkg::PORT1_CROSSBAR_SKIP_RST;
			port1_analog_select_reg     <= ppcr_pkg::PORT1_ANALOG_SELECT_RST;
			rdata_reg                   <= 8'h00;
			rvalid_reg                  <= 1'b0;
		end else begin
			port1_data_latch_reg        <= port1_data_latch_next;
			port1_output_drive_mode_reg <= port1_output_drive_mode_next;
			port0_crossbar_skip_reg     <= port0_crossbar_skip_next;
			port1_crossbar_skip_reg     <= port1_crossbar_skip_next;
			port1_analog_select_reg     <= port1_analog_select_next;
			rdata_reg                   <= rdata_next;
			rvalid_reg                  <= rvalid_next;
		end
	end

	// ****************************************
	// pin input synchroniser
	// ****************************************
	// two stages against metastability; the price is that a pin change
	// reaches a read only two edges after it settles
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_meta_reg <= 8'h00;
			pin_sync_reg <= 8'h00;
		end else begin
			pin_meta_reg <= port1_pin_in;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// ****************************************
	// pad control, per pin
	// ****************************************
	ppcr_pkg::ppcr_pin_drive_t pad_next;
	ppcr_pkg::ppcr_pin_drive_t pad_reg;
	logic [7:0]                skip0_reg;
	logic [7:0]                skip1_reg;

	// registered from the _next values so pads follow a write by one edge
	for (genvar i = 0; i < ppcr_pkg::PORT_WIDTH; i++) begin : g_pad
		always_comb begin
			pad_next.out[i]       = port1_data_latch_next[i];
			pad_next.dig_in_en[i] = port1_analog_select_next[i];
			if (!port1_analog_select_next[i]) begin
				// analog: drive mode ignored, everything off
				pad_next.oe[i]        = 1'b0;
				pad_next.pullup_en[i] = 1'b0;
			end else if (port1_output_drive_mode_next[i]) begin
				// push-pull drives both levels, so the pull-up stays off
				pad_next.oe[i]        = 1'b1;
				pad_next.pullup_en[i] = 1'b0;
			end else begin
				// open drain: pull low only, release to weak pull-up
				pad_next.oe[i]        = ~port1_data_latch_next[i];
				pad_next.pullup_en[i] = port1_data_latch_next[i];
			end
		end
	end

	// pads and skip masks are flops so the pins never see decode glitches
	always_ff @(posedge clk) begin
		if (rst) begin
			pad_reg.out       <= ppcr_pkg::PORT1_DATA_LATCH_RST;
			pad_reg.oe        <= 8'h00;
			pad_reg.pullup_en <= ppcr_pkg::PORT1_DATA_LATCH_RST;
			pad_reg.dig_in_en <= ppcr_pkg::PORT1_ANALOG_SELECT_RST;
			skip0_reg         <= ppcr_pkg::PORT0_CROSSBAR_SKIP_RST;
			skip1_reg         <= ppcr_pkg::PORT1_CROSSBAR_SKIP_RST;
		end else begin
			pad_reg   <= pad_next;
			skip0_reg <= port0_crossbar_skip_next;
			skip1_reg <= port1_crossbar_skip_next;
		end
	end

	// every output comes straight from a flip-flop
	assign port1_pad      = pad_reg;
	assign port0_skip_out = skip0_reg;
	assign port1_skip_out = skip1_reg;
	assign sfr_rdata      = rdata_reg;
	assign sfr_rvalid     = rvalid_reg;

endmodule

// ===== verif/ppcr_pins.sv
// board model for the port 1 pins: drivers, pull-ups, external sources
// assumes external sources are stronger than the weak pull-up only
module ppcr_board (
	// pad control from the block
	input  wire ppcr_pkg::ppcr_pin_drive_t pad,
	// external sources, per pin
	input  wire logic [7:0]               ext_en,
	input  wire logic [7:0]               ext_val,
	// resolved pin levels
	output logic [7:0]                    pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// undriven pin with no pull-up settles low
	assign pin = (pad.oe & pad.out) | (~pad.oe & ext_en & ext_val)
		| (~pad.oe & ~ext_en & pad.pullup_en);
endmodule

// ===== verif/ppcr_port_regs_sva.sv
// checker for the port registers, sees only the top module ports
// assumes one clock and synchronous active-high reset
module ppcr_port_regs_sva (
	input wire logic                    clk,
	input wire logic                    rst,
	input wire ppcr_pkg::ppcr_sfr_req_t sfr_req,
	input wire logic [7:0]              sfr_rdata,
	input wire logic                    sfr_rvalid,
	input wire logic [7:0]              port1_pin_in,
	input wire ppcr_pkg::ppcr_pin_drive_t port1_pad,
	input wire logic [7:0]              port0_skip_out,
	input wire logic [7:0]              port1_skip_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic byte_wr;
	assign byte_wr = sfr_req.wr && !sfr_req.bit_op;
	a_read_answer: assert property (sfr_req.rd |=> sfr_rvalid)
		else $error("read not answered");
	a_skip0_write: assert property (byte_wr && sfr_req.addr == 8'hd4 |=>
		port0_skip_out == $past(sfr_req.wdata)) else $error("skip0 wrong");
	a_skip1_write: assert property (byte_wr && sfr_req.addr == 8'hd5 |=>
		port1_skip_out == $past(sfr_req.wdata)) else $error("skip1 wrong");
	a_latch_drive: assert property (byte_wr && sfr_req.addr == 8'h90 |=>
		port1_pad.out == $past(sfr_req.wdata)) else $error("latch wrong");
	a_bit_write: assert property (sfr_req.wr && sfr_req.bit_op
		&& sfr_req.addr[7:3] == 5'h12
		|=> port1_pad.out[$past(sfr_req.addr[2:0])]
		== $past(sfr_req.wdata[0])) else $error("bit write wrong");
	a_rmw_latch: assert property (sfr_req.rd && sfr_req.rmw
		&& !sfr_req.bit_op && sfr_req.addr == 8'h90
		|=> sfr_rdata == $past(port1_pad.out))
		else $error("rmw read wrong");
	a_input_mode: assert property (byte_wr && sfr_req.addr == 8'hf2 |=>
		port1_pad.dig_in_en == $past(sfr_req.wdata))
		else $error("input mode wrong");
	a_analog_off: assert property (((port1_pad.oe | port1_pad.pullup_en)
		& ~port1_pad.dig_in_en) == 8'h00) else $error("analog pin active");
	a_digital_drive: assert property ((port1_pad.dig_in_en
		& ~(port1_pad.oe | port1_pad.pullup_en)) == 8'h00)
		else $error("digital pin undriven");
	a_pullup_high: assert property ((port1_pad.pullup_en
		& ~port1_pad.out) == 8'h00) else $error("pull-up on low latch");
endmodule
bind ppcr_port_regs ppcr_port_regs_sva i_sva (.clk(clk), .rst(rst),
	.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
	.port1_pin_in(port1_pin_in), .port1_pad(port1_pad),
	.port0_skip_out(port0_skip_out), .port1_skip_out(port1_skip_out));

// ===== verif/tb_top.sv
// testbench for the port registers: byte/bit register access and pin checks
// assumes the board model resolves the pins; inputs change at falling edge
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1;
	ppcr_pkg::ppcr_sfr_req_t req = '0;
	logic [7:0] rdata, p0s, p1s, pin, ext_en = 8'h00, ext_val = 8'h00;
	logic rvalid;
	ppcr_pkg::ppcr_pin_drive_t pad;
	int mismatches = 0, n_compared = 0;
	ppcr_port_regs i_dut (.clk(clk), .rst(rst), .sfr_req(req),
		.sfr_rdata(rdata), .sfr_rvalid(rvalid), .port1_pin_in(pin),
		.port1_pad(pad), .port0_skip_out(p0s), .port1_skip_out(p1s));
	ppcr_board i_board (.pad(pad), .ext_en(ext_en), .ext_val(ext_val),
		.pin(pin));
	initial forever #10 clk = ~clk;
	// ****************************************
	// access tasks
	// ****************************************
	task chk(string what, logic [7:0] seen, logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(logic [7:0] a, logic [7:0] d, logic bo = 1'b0);
		req = '{1'b1, 1'b0, bo, 1'b0, a, d};
		@(negedge clk);
	endtask
	task rd(logic [7:0] a, logic [7:0] exp, logic bo = 1'b0,
		logic rmw = 1'b0);
		req = '{1'b0, 1'b1, bo, rmw, a, 8'h00};
		@(negedge clk);
		chk("rvalid", {7'h00, rvalid}, 8'h01);
		chk("rdata", rdata, exp);
	endtask
	// lets the pin synchronizer settle
	task idle();
		req = '0;
		repeat (4) @(negedge clk);
	endtask
	task wrap_up();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#100us;
		mismatches++;
		wrap_up();
	end
	// ****************************************
	// tests
	// ****************************************
	initial begin
		repeat (2) @(negedge clk);
		rst = 0;
		idle();
		rd(8'h90, 8'hff);
		rd(8'hf2, 8'hff);
		rd(8'ha5, 8'h00);
		rd(8'hd4, 8'h00);
		rd(8'hd5, 8'h00);
		rd(8'h91, 8'h00);
		wr(8'hd4, 8'ha5);
		wr(8'hd5, 8'h3c);
		idle();
		chk("skip0", p0s, 8'ha5);
		chk("skip1", p1s, 8'h3c);
		rd(8'hd5, 8'h3c);
		wr(8'h90, 8'h5a);
		idle();
		chk("out", pad.out, 8'h5a);
		chk("oe", pad.oe, 8'ha5);
		rd(8'h90, 8'h5a);
		wr(8'h90, 8'hff);
		ext_en = 8'h0f;
		idle();
		rd(8'h90, 8'hf0);
		rd(8'h90, 8'hff, 0, 1);
		wr(8'h93, 8'h00, 1);
		// a bit address outside the port group must leave the latch alone
		wr(8'h81, 8'h00, 1);
		wr(8'ha5, 8'hff);
		idle();
		rd(8'h93, 8'h00, 1, 1);
		rd(8'h90, 8'hf7, 0, 1);
		chk("pp oe", pad.oe, 8'hff);
		chk("pp pull", pad.pullup_en, 8'h00);
		ext_en = 8'hff;
		ext_val = 8'hff;
		wr(8'hf2, 8'hf0);
		idle();
		chk("an oe", pad.oe, 8'hf0);
		chk("an pull", pad.pullup_en, 8'h00);
		chk("an in", pad.dig_in_en, 8'hf0);
		rd(8'h90, 8'hf0);
		rd(8'h94, 8'h01, 1);
		rd(8'h92, 8'h00, 1);
		rd(8'hf2, 8'hf0);
		rd(8'ha5, 8'hff);
		rst = 1;
		@(negedge clk);
		rst = 0;
		idle();
		rd(8'h90, 8'hff, 0, 1);
		chk("rst oe", pad.oe, 8'h00);
		wrap_up();
	end
endmodule
